// >>> adcsc_pkg.sv
/*
 * Constants, field layout and types for the converter sample/convert
 * control block. Assumes a 16-bit register port with 6-bit word index.
 */
package adcsc_pkg;
    localparam int AW        = 6;
    localparam int DW        = 16;
    localparam int RES_W     = 10;
    localparam int BUF_WORDS = 32;
    localparam int CH_W      = 5;
    localparam int NUM_CH    = 24;
    localparam logic [AW-1:0] REG_CTRL1 = 6'h00;
    localparam logic [AW-1:0] REG_CTRL2 = 6'h01;
    localparam logic [AW-1:0] REG_CTRL3 = 6'h02;
    localparam logic [AW-1:0] REG_CHSEL = 6'h03;
    localparam logic [AW-1:0] REG_BUF   = 6'h20;
    localparam logic [DW-1:0] CTRL1_WMASK = 16'hA3E4;
    localparam logic [DW-1:0] CTRL2_WMASK = 16'hE47F;
    localparam logic [DW-1:0] CTRL3_WMASK = 16'h9FFF;
    localparam logic [DW-1:0] CHSEL_WMASK = 16'h9F9F;
    localparam logic [DW-1:0] REG_RESET   = 16'h0000;
    localparam int ON_BIT   = 15;
    localparam int IDLE_BIT = 13;
    localparam int RESULT_FORMAT_LSB = 8;
    localparam int TRIGGER_SOURCE_LSB = 5;
    localparam int SAMPLE_AUTOSTART_BIT = 2;
    localparam int SAMPLE_ENABLE_BIT = 1;
    localparam int DONE_BIT = 0;
    localparam int REFERENCE_SELECT_LSB = 13;
    localparam int FILL_HALF_STATUS_BIT = 7;
    localparam int SEQUENCES_PER_IRQ_LSB = 2;
    localparam int BUFFER_SPLIT_MODE_BIT = 1;
    localparam int ALTERNATE_MUX_SAMPLE_BIT = 0;
    localparam int SAMC_LSB = 8;
    localparam int CHA_LSB  = 0;
    localparam int CHB_LSB  = 8;
    typedef enum logic [2:0] {
        TRG_SW   = 3'b000,
        TRG_EXT  = 3'b001,
        TRG_T3   = 3'b010,
        TRG_T5   = 3'b100,
        TRG_CTU  = 3'b110,
        TRG_AUTO = 3'b111
    } adcsc_trig_t;
    typedef enum logic [1:0] {
        FMT_INT  = 2'b00,
        FMT_SINT = 2'b01,
        FMT_FRAC = 2'b10,
        FMT_SFRC = 2'b11
    } adcsc_fmt_t;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10
    } adcsc_state_t;
endpackage

// >>> adcsc_fmt_if.sv
/*
 * Carrier between the control core and the result formatter.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface adcsc_fmt_if;
    logic [9:0]  raw;
    logic [1:0]  result_format;
    logic [15:0] word;
    modport ctl (output raw, output result_format, input word);
    modport fmt (input raw, input result_format, output word);
endinterface

// >>> adcsc_formatter.sv
/*
 * Result formatter: places a 10-bit code into a 16-bit word.
 * Assumes the core delivers offset-binary codes.
 */
`timescale 1ns/100ps
module adcsc_formatter (
    adcsc_fmt_if.fmt f
);
    import adcsc_pkg::*;

    // signed modes flip the msb to turn offset binary into two's complement
    function automatic logic [15:0] fmt_word(input logic [9:0] r, input logic [1:0] m);
        logic [9:0] s;
        s = {~r[9], r[8:0]};
        case (m)
            FMT_INT:  fmt_word = {6'h00, r};
            FMT_SINT: fmt_word = {{6{s[9]}}, s};
            FMT_FRAC: fmt_word = {r, 6'h00};
            default:  fmt_word = {s, 6'h00};
        endcase
    endfunction

    assign f.word = fmt_word(f.raw, f.result_format);
endmodule

// >>> adcsc_ctrl.sv
/*
 * Sample/convert control for a 10-bit SAR converter: control registers,
 * trigger selection, sequencer, result buffer and irq-rate counter.
 * Assumes register port, triggers and core handshake are synchronous
 * to clk_in; the core answers each start with one done pulse.
 */
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
module adcsc_ctrl (
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    input  wire logic [adcsc_pkg::AW-1:0]      reg_addr_in,
    input  wire logic [adcsc_pkg::DW-1:0]      reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [adcsc_pkg::DW-1:0]      reg_rdata_out,
    input  wire logic                          idle_mode_in,
    input  wire logic                          third_timer_in,
    input  wire logic                          fifth_timer_in,
    input  wire logic                          ext_interrupt_zero_pin_in,
    input  wire logic                          charge_time_unit_in,
    input  wire logic                          conv_done_in,
    input  wire logic [adcsc_pkg::RES_W-1:0]   conv_result_in,
    output logic                               sample_enable_out,
    output logic                               conv_start_out,
    output logic      [adcsc_pkg::CH_W-1:0]    chan_sel_out,
    output logic      [2:0]                    reference_select_out,
    output logic                               converter_irq_flag_out,
    output logic                               module_on_out
);
    import adcsc_pkg::*;

    logic [DW-1:0]    ctrl1_q;
    logic [DW-1:0]    ctrl2_q;
    logic [DW-1:0]    ctrl3_q;
    logic [DW-1:0]    chsel_q;
    logic             sample_enable_q;
    logic             done_q;
    logic             fill_half_status_q;
    adcsc_state_t     state_q;
    logic [7:0]       tad_q;
    logic [4:0]       samc_cnt_q;
    logic             alt_q;
    logic             ext_q;
    logic [4:0]       ptr_q;
    logic [4:0]       seq_q;
    logic [RES_W-1:0] buf_q [BUF_WORDS];
    logic [DW-1:0]    rdata_q;
    logic             irq_q;
    logic             start_q;
    logic [CH_W-1:0]  chan_q;
    logic             on_q;
    logic             run;
    logic             wr_c1;
    logic             sw_set;
    logic             sw_clr;
    logic             samc_hit;
    logic             trig;
    logic             accept;
    logic             irq_due;
    adcsc_trig_t      trigger_source;
    adcsc_fmt_if      fmt_bus ();

    function automatic logic [DW-1:0] wmask(input logic [DW-1:0] old,
                                            input logic [DW-1:0] nw,
                                            input logic [DW-1:0] m);
        wmask = (old & ~m) | (nw & m);
    endfunction

    // decoded control fields
    assign on_q     = ctrl1_q[ON_BIT];
    assign trigger_source     = adcsc_trig_t'(ctrl1_q[TRIGGER_SOURCE_LSB +: 3]);
    assign run      = on_q & ~(ctrl1_q[IDLE_BIT] & idle_mode_in);
    assign wr_c1    = reg_wr_in & (reg_addr_in == REG_CTRL1);
    assign sw_set   = wr_c1 & reg_wdata_in[SAMPLE_ENABLE_BIT];
    assign sw_clr   = wr_c1 & ~reg_wdata_in[SAMPLE_ENABLE_BIT];
    assign samc_hit = (samc_cnt_q >= ctrl3_q[SAMC_LSB +: 5]);
    assign accept   = run & (state_q == ST_CONV) & conv_done_in;
    assign irq_due  = (seq_q == ctrl2_q[SEQUENCES_PER_IRQ_LSB +: 5]);

    // trigger selection; reserved codes never end sampling
    always_comb begin
        case (trigger_source)
            TRG_SW:   trig = sw_clr;
            TRG_EXT:  trig = ext_interrupt_zero_pin_in & ~ext_q;
            TRG_T3:   trig = third_timer_in;
            TRG_T5:   trig = fifth_timer_in;
            TRG_CTU:  trig = charge_time_unit_in;
            TRG_AUTO: trig = samc_hit;
            default:  trig = 1'b0;
        endcase
    end

    // software-written control registers, unimplemented bits held at zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl1_q <= REG_RESET;
            ctrl2_q <= REG_RESET;
            ctrl3_q <= REG_RESET;
            chsel_q <= REG_RESET;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL1: ctrl1_q <= wmask(ctrl1_q, reg_wdata_in, CTRL1_WMASK);
                REG_CTRL2: ctrl2_q <= wmask(ctrl2_q, reg_wdata_in, CTRL2_WMASK);
                REG_CTRL3: ctrl3_q <= wmask(ctrl3_q, reg_wdata_in, CTRL3_WMASK);
                REG_CHSEL: chsel_q <= wmask(chsel_q, reg_wdata_in, CHSEL_WMASK);
                default:   ctrl1_q <= ctrl1_q;
            endcase
        end
    end

    // edge detector for the external pin; pin is already synchronous
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_interrupt_zero_pin_in;
        end
    end

    // sample/convert sequencer; frozen (not reset) while halted in idle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ST_IDLE;
            sample_enable_q  <= 1'b0;
            done_q  <= 1'b0;
            start_q <= 1'b0;
            alt_q   <= 1'b0;
        end else if (!on_q) begin
            state_q <= ST_IDLE;
            sample_enable_q  <= 1'b0;
            done_q  <= 1'b0;
            start_q <= 1'b0;
            alt_q   <= 1'b0;
        end else if (run) begin
            start_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (ctrl1_q[SAMPLE_AUTOSTART_BIT] | sw_set) begin
                        state_q <= ST_SAMPLE;
                        sample_enable_q  <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (trig) begin
                        state_q <= ST_CONV;
                        sample_enable_q  <= 1'b0;
                        done_q  <= 1'b0;
                        start_q <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (conv_done_in) begin
                        done_q <= 1'b1;
                        alt_q  <= ~alt_q & ctrl2_q[ALTERNATE_MUX_SAMPLE_BIT];
                        if (ctrl1_q[SAMPLE_AUTOSTART_BIT]) begin
                            state_q <= ST_SAMPLE;
                            sample_enable_q  <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end else begin
            start_q <= 1'b0;
        end
    end

    // sample-time counter: samc ticks of (adcs + 1) clocks each
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tad_q      <= 8'h00;
            samc_cnt_q <= 5'h00;
        end else if (state_q != ST_SAMPLE || !run) begin
            tad_q      <= 8'h00;
            samc_cnt_q <= (state_q == ST_SAMPLE) ? samc_cnt_q : 5'h00;
        end else if (tad_q == ctrl3_q[7:0]) begin
            tad_q <= 8'h00;
            if (!samc_hit) begin
                samc_cnt_q <= samc_cnt_q + 5'h01;
            end
        end else begin
            tad_q <= tad_q + 8'h01;
        end
    end

    // channel choice: mux A first, then B and A in turn when alternating
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chan_q <= 5'h00;
        end else if (alt_q) begin
            chan_q <= chsel_q[CHB_LSB +: CH_W];
        end else begin
            chan_q <= chsel_q[CHA_LSB +: CH_W];
        end
    end

    // result buffer and irq-rate counter; cleared while the module is off
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_q  <= 5'h00;
            seq_q  <= 5'h00;
            fill_half_status_q <= 1'b0;
            irq_q  <= 1'b0;
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_q[i] <= '0;
            end
        end else if (!on_q) begin
            ptr_q  <= 5'h00;
            seq_q  <= 5'h00;
            fill_half_status_q <= 1'b0;
            irq_q  <= 1'b0;
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_q[i] <= '0;
            end
        end else begin
            irq_q <= 1'b0;
            if (accept) begin
                buf_q[ptr_q] <= conv_result_in;
                if (irq_due) begin
                    seq_q <= 5'h00;
                    irq_q <= 1'b1;
                    if (ctrl2_q[BUFFER_SPLIT_MODE_BIT]) begin
                        fill_half_status_q <= ~fill_half_status_q;
                        ptr_q  <= {~fill_half_status_q, 4'h0};
                    end else begin
                        ptr_q <= 5'h00;
                    end
                end else begin
                    seq_q <= seq_q + 5'h01;
                    ptr_q <= ptr_q + 5'h01; // wraps within 32 words
                end
            end
        end
    end

    // formatting happens on the read path so a format change applies at once
    assign fmt_bus.raw  = buf_q[reg_addr_in[4:0]];
    assign fmt_bus.result_format = ctrl1_q[RESULT_FORMAT_LSB +: 2];

    adcsc_formatter u_fmt (
        .f (fmt_bus.fmt)
    );

    // read data one cycle after the strobe; unmapped words read zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_in) begin
            if (reg_addr_in[5]) begin
                rdata_q <= fmt_bus.word;
            end else begin
                case (reg_addr_in)
                    REG_CTRL1: rdata_q <= ctrl1_q | {14'h0000, sample_enable_q, done_q};
                    REG_CTRL2: rdata_q <= ctrl2_q | {8'h00, fill_half_status_q, 7'h00};
                    REG_CTRL3: rdata_q <= ctrl3_q;
                    REG_CHSEL: rdata_q <= chsel_q;
                    default:   rdata_q <= 16'h0000;
                endcase
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // registered outputs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reference_select_out <= 3'h0;
            module_on_out        <= 1'b0;
        end else begin
            reference_select_out <= ctrl2_q[REFERENCE_SELECT_LSB +: 3];
            module_on_out        <= on_q;
        end
    end

    assign reg_rdata_out          = rdata_q;
    assign sample_enable_out      = sample_enable_q;
    assign conv_start_out         = start_q;
    assign chan_sel_out           = chan_q;
    assign converter_irq_flag_out = irq_q;

    sequence s_sampling;
        run && state_q == ST_SAMPLE;
    endsequence

    sequence s_acquire_again;
        ##1 sample_enable_q && state_q == ST_SAMPLE;
    endsequence

    chk_off_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !on_q |=> state_q == ST_IDLE && !sample_enable_q && !start_q)
        else $error("sequencer active while off");
    chk_idle_halt: assert property (@(posedge clk_in) disable iff (!resetn_in)
        on_q && !run |=> $stable(state_q) && !start_q)
        else $error("sequencer moved in idle halt");
    chk_fmt_int: assert property (@(posedge clk_in) disable iff (!resetn_in)
        fmt_bus.result_format == FMT_INT |-> fmt_bus.word[15:10] == 6'h00)
        else $error("integer format upper bits not zero");
    chk_fmt_left: assert property (@(posedge clk_in) disable iff (!resetn_in)
        fmt_bus.result_format[1] |-> fmt_bus.word[5:0] == 6'h00 && fmt_bus.word[14:6] == fmt_bus.raw[8:0])
        else $error("fractional format misplaced");
    chk_auto_trig: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_sampling ##0 (trigger_source == TRG_AUTO && samc_hit) |=> start_q && !sample_enable_q)
        else $error("sample counter did not start conversion");
    chk_timer_trig: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_sampling ##0 (trigger_source == TRG_T5 && fifth_timer_in) |=> state_q == ST_CONV)
        else $error("fifth timer did not start conversion");
    chk_sw_trig: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_sampling ##0 (trigger_source == TRG_SW && sw_clr) |=> start_q ##1 !start_q)
        else $error("software clear did not start one conversion");
    chk_autostart: assert property (@(posedge clk_in) disable iff (!resetn_in)
        accept && ctrl1_q[SAMPLE_AUTOSTART_BIT] |-> s_acquire_again)
        else $error("auto-start did not resume sampling");
    chk_no_auto: assert property (@(posedge clk_in) disable iff (!resetn_in)
        run && state_q == ST_IDLE && !ctrl1_q[SAMPLE_AUTOSTART_BIT] && !sw_set |=> !sample_enable_q)
        else $error("sampling began without request");
    chk_done_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
        accept |=> done_q [*1] ##0 (state_q != ST_CONV))
        else $error("status not set after conversion");
    chk_irq_rate: assert property (@(posedge clk_in) disable iff (!resetn_in)
        irq_q |-> $past(accept) && $past(seq_q) == $past(ctrl2_q[SEQUENCES_PER_IRQ_LSB +: 5]))
        else $error("irq at wrong sequence count");
    chk_split_half: assert property (@(posedge clk_in) disable iff (!resetn_in)
        irq_q && ctrl2_q[BUFFER_SPLIT_MODE_BIT] |-> ptr_q[4] == fill_half_status_q)
        else $error("fill half status mismatches pointer");
    chk_unimpl_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == REG_CTRL1 |=> reg_rdata_out[14] == 1'b0
        && reg_rdata_out[12:10] == 3'h0 && reg_rdata_out[4:3] == 2'h0)
        else $error("unimplemented bits read nonzero");
    chk_t3_trig: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_sampling ##0 (trigger_source == TRG_T3 && third_timer_in) |=> state_q == ST_CONV)
        else $error("third timer did not start conversion");
    chk_ext_edge: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_sampling ##0 (trigger_source == TRG_EXT && $rose(ext_interrupt_zero_pin_in)) |=> start_q)
        else $error("external pin edge did not start conversion");
    chk_rsvd_none: assert property (@(posedge clk_in) disable iff (!resetn_in)
        trigger_source == 3'h3 || trigger_source == 3'h5 |=> !start_q)
        else $error("reserved trigger code started a conversion");
    chk_buf_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !on_q |=> ptr_q == 5'h00 && seq_q == 5'h00 && fmt_bus.raw == 10'h000)
        else $error("result buffer kept while off");
endmodule

// >>> adcsc_core_model.sv
/* Behavioural model of the analog sample/hold and SAR core.
   Assumes conv_start_in is a one-cycle pulse synchronous to clk_in. */
`timescale 1ns/100ps
module adcsc_core_model (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       conv_start_in,
    input  wire logic [3:0] delay_in,
    input  wire logic [9:0] code_in,
    output logic            conv_done_out,
    output logic [9:0]      conv_result_out
);
    logic [3:0] cnt_q;
    logic       busy_q;

    // conversion takes delay_in+1 clocks; the result bus toggles when not valid
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            conv_done_out <= 1'b0;
            conv_result_out <= 10'h155;
        end else begin
            conv_done_out <= 1'b0;
            conv_result_out <= ~conv_result_out;
            if (conv_start_in) begin
                busy_q <= 1'b1;
                cnt_q <= delay_in;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                conv_done_out <= 1'b1;
                conv_result_out <= code_in;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// >>> adcsc_ctrl_bench.sv
/* Self-checking bench for the converter sample/convert control.
   Assumes adcsc_pkg, the design files and adcsc_core_model come first. */
`timescale 1ns/100ps
module adcsc_ctrl_bench;
    import adcsc_pkg::*;
    logic          clk_in, resetn_in, wr_q, rd_q, idle_q;
    logic          se, cs, irq, mod_on, done;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] wdata_q, rdata, x, c1;
    logic [3:0]    src_q, dly_q;
    logic [9:0]    code_q, cres, res_q;
    logic [4:0]    chan;
    logic [2:0]    refs;
    logic [2:0]    codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    logic [DW-1:0] wm [4] = '{CTRL1_WMASK, CTRL2_WMASK, CTRL3_WMASK, CHSEL_WMASK};
    int failures = 0, n_checks = 0, n_starts = 0, n_dones = 0, n_irqs = 0;
    int seed = 33874, i, s0;

    adcsc_ctrl adcsc_ctrl_i (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr_q),
        .reg_wdata_in(wdata_q), .reg_wr_in(wr_q), .reg_rd_in(rd_q), .reg_rdata_out(rdata),
        .idle_mode_in(idle_q), .third_timer_in(src_q[1]), .fifth_timer_in(src_q[2]),
        .ext_interrupt_zero_pin_in(src_q[0]), .charge_time_unit_in(src_q[3]),
        .conv_done_in(done), .conv_result_in(cres), .sample_enable_out(se),
        .conv_start_out(cs), .chan_sel_out(chan), .reference_select_out(refs),
        .converter_irq_flag_out(irq), .module_on_out(mod_on));
    adcsc_core_model adcsc_core_model_i (.clk_in(clk_in), .resetn_in(resetn_in),
        .conv_start_in(cs), .delay_in(dly_q), .code_in(code_q), .conv_done_out(done),
        .conv_result_out(cres));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // event counters; a new random code and core delay follow every start
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            code_q <= 10'h000;
            dly_q <= 4'h2;
        end else if (cs) begin
            n_starts <= n_starts + 1;
            code_q <= 10'($random(seed));
            dly_q <= 4'($random(seed)) & 4'h7;
        end
        if (irq) n_irqs <= n_irqs + 1;
        if (done) begin
            n_dones <= n_dones + 1;
            res_q <= cres;
        end
    end

    function automatic logic [15:0] fmt_word(input logic [9:0] r, input logic [1:0] f);
        logic [9:0] s;
        s = {~r[9], r[8:0]};
        case (f)
            2'h0: fmt_word = {6'h00, r};
            2'h1: fmt_word = {{6{s[9]}}, s};
            2'h2: fmt_word = {r, 6'h00};
            default: fmt_word = {s, 6'h00};
        endcase
    endfunction

    function automatic logic [3:0] src_of(input logic [2:0] t);
        case (t)
            3'h1: src_of = 4'h1;
            3'h2: src_of = 4'h2;
            3'h4: src_of = 4'h4;
            3'h6: src_of = 4'h8;
            default: src_of = 4'h0;
        endcase
    endfunction

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // bounded wait on the start (0) or done (1) counter
    task automatic wait_ev(input int which, input int target);
        int k;
        for (k = 0; k < 300; k++) begin
            if ((which == 0 ? n_starts : n_dones) >= target) begin
                n_checks++;
                return;
            end
            @(posedge clk_in);
        end
        failures++;
        $display("BAD at %0t: got %0h expected %0h", $time, which, target);
        finish_test();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_in);
        addr_q <= a;
        wdata_q <= d;
        wr_q <= 1'b1;
        @(posedge clk_in);
        wr_q <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_in);
        addr_q <= a;
        rd_q <= 1'b1;
        @(posedge clk_in);
        rd_q <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pulse(input logic [3:0] m);
        @(posedge clk_in);
        src_q <= m;
        @(posedge clk_in);
        src_q <= 4'h0;
    endtask

    // one sample/convert sequence with the trigger held in c1; wrong sources first unless the trigger is automatic
    task automatic conv();
        logic [2:0] t;
        int s, d;
        t = c1[7:5];
        s = n_starts;
        d = n_dones;
        wr(REG_CTRL1, c1 | 16'h0002);
        if (t != 3'h7) begin
            tick(2);
            chk({15'h0, se}, 16'h0001);
            pulse(~src_of(t));
            tick(4);
            chk(16'(n_starts), 16'(s));
            if (t == 3'h0) wr(REG_CTRL1, c1);
            else pulse(src_of(t));
        end
        wait_ev(0, s + 1);
        wait_ev(1, d + 1);
        tick(2);
    endtask

    initial begin
        {wr_q, rd_q, idle_q, resetn_in} = 4'h0;
        addr_q = 6'h00;
        wdata_q = 16'h0000;
        src_q = 4'h0;
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        // reset values, writable bits, unimplemented bits, unmapped index
        for (i = 0; i < 4; i++) begin
            rd(6'(i), x);
            chk(x, REG_RESET);
            x = 16'($random(seed)) & 16'h7FFF;
            wr(6'(i), x);
            rd(6'(i), c1);
            chk(c1, x & wm[i]);
        end
        wr(REG_CTRL1, 16'h7FFB);
        rd(REG_CTRL1, x);
        chk(x, 16'h23E0);
        wr(REG_CTRL2, 16'hA000);
        tick(2);
        chk({13'h0, refs}, 16'h0005);
        wr(6'h10, 16'hFFFF);
        rd(6'h10, x);
        chk(x, 16'h0000);
        for (i = 0; i < 4; i++) wr(6'(i), 16'h0000);
        $display("test registers done");
        // every trigger source and every result format
        wr(REG_CTRL3, 16'h0300);
        for (i = 0; i < 6; i++) begin
            c1 = {8'h00, codes[i], 5'h00} | (16'(i % 4) << RESULT_FORMAT_LSB);
            wr(REG_CTRL1, c1);
            chk({15'h0, irq}, 16'h0000);
            c1 = c1 | 16'h8000;
            wr(REG_CTRL1, c1);
            s0 = n_irqs;
            conv();
            rd(REG_CTRL1, x);
            chk(x, c1 | 16'h0001);
            chk(16'(n_irqs), 16'(s0 + 1));
            rd(REG_BUF, x);
            chk(x, fmt_word(res_q, c1[9:8]));
            wr(REG_CTRL1, 16'h0000);
            rd(REG_BUF, x);
            chk(x, 16'h0000);
        end
        $display("test triggers done");
        // reserved codes never trigger; module off ignores everything
        for (i = 3; i < 6; i += 2) begin
            c1 = 16'h8000 | 16'(i << TRIGGER_SOURCE_LSB);
            wr(REG_CTRL1, c1 & 16'h7FFF);
            wr(REG_CTRL1, c1);
            s0 = n_starts;
            wr(REG_CTRL1, c1 | 16'h0002);
            pulse(4'hF);
            tick(8);
            chk(16'(n_starts), 16'(s0));
            chk({15'h0, se}, 16'h0001);
            wr(REG_CTRL1, 16'h0000);
            pulse(4'hF);
            tick(4);
            chk({14'h0, se, mod_on}, 16'h0000);
            chk(16'(n_starts), 16'(s0));
        end
        $display("test reserved done");
        // irq rate, buffer order, split halves and mux alternation
        wr(REG_CTRL2, 16'h0008);
        c1 = 16'h8000;
        wr(REG_CTRL1, c1);
        s0 = n_irqs;
        for (i = 0; i < 3; i++) begin
            chk(16'(n_irqs), 16'(s0));
            conv();
        end
        chk(16'(n_irqs), 16'(s0 + 1));
        rd(REG_BUF + 6'h02, x);
        chk(x, {6'h00, res_q});
        wr(REG_CTRL1, 16'h0000);
        wr(REG_CTRL2, 16'h0003);
        wr(REG_CHSEL, 16'h0017);
        wr(REG_CTRL1, c1);
        tick(3);
        chk({10'h0, mod_on, chan}, 16'h0037);
        for (i = 0; i < 2; i++) begin
            conv();
            rd(REG_CTRL2, x);
            chk(x, (i == 0) ? 16'h0003 | (16'h0001 << FILL_HALF_STATUS_BIT) : 16'h0003);
            chk({11'h0, chan}, (i == 0) ? 16'h0000 : 16'h0017);
            rd(REG_BUF + 6'(i * 16), x);
            chk(x, {6'h00, res_q});
        end
        $display("test buffer done");
        // auto-start with the sample counter, then idle halt and idle run
        wr(REG_CTRL1, 16'h0000);
        wr(REG_CTRL2, 16'h0000);
        wr(REG_CTRL3, 16'h1F00);
        wr(REG_CTRL1, 16'h20E4);
        wr(REG_CTRL1, 16'hA0E4);
        wait_ev(1, n_dones + 2);
        tick(3);
        chk({15'h0, se}, 16'h0001);
        wait_ev(1, n_dones + 1);
        idle_q <= 1'b1;
        s0 = n_starts;
        tick(100);
        chk(16'(n_starts), 16'(s0));
        @(posedge clk_in);
        idle_q <= 1'b0;
        wait_ev(0, s0 + 1);
        wr(REG_CTRL1, 16'h80E4);
        idle_q <= 1'b1;
        wait_ev(0, n_starts + 2);
        idle_q <= 1'b0;
        wr(REG_CTRL1, 16'h0000);
        tick(3);
        chk({14'h0, se, mod_on}, 16'h0000);
        $display("test autostart done");
        finish_test();
    end
endmodule
